// >>> design/drive_boot_config_select.sv
// Overview of operation
// [RULE1] ground selects canopen, else vendor protocol
// [RULE2] protocol comes only from the pin
// [RULE3] vendor protocol boots into autorun by default
// [RULE4] autorun starts valid program at motor supply
// [RULE5] writing 0001 at word 4000 cancels autorun
// [RULE6] grounding select pin leaves autorun mode; code leaves only from BOOT_WAIT, BOOT_RUN ignores the pin
// [RULE7] canopen never starts a program automatically
// [RULE8] host may then invalidate the stored program
// [RULE9] no valid program means slave mode
// [RULE10] axis switch read as four bit value
// [RULE11] switch zero gives 255 or 127
// [RULE12] software identifier overrides the switch
// [RULE13] switch used only when software at hardware
// [RULE14] no switch behaves like switch zero
// [RULE15] both select pins must agree; board model grounds the net if either pin is grounded
// [RULE16] supply above 53 volts disables power stage
// [RULE17] straps sampled once at reset release
`default_nettype none
module drive_boot_config_select
   import boot_cfg_pkg::*;
#(
   parameter bit HAS_SWITCH = 1'b1  // switch fitted on this variant
)(
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        proto_sel_pin,
   input  wire logic [3:0]  axis_id_switch,
   input  wire logic        motor_supply_on,
   input  wire logic [15:0] motor_supply_mv,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic             pslverr,
   output logic      [31:0] prdata,
   output logic             canopen_selected,
   output logic      [7:0]  node_axis_identifier,
   output logic             program_run,
   output logic             power_stage_en,
   output logic             irq
);
   boot_if straps ();

   logic [7:0]  id_comb;          // resolved identifier
   logic [7:0]  id_reg;           // registered identifier
   logic        pin_s1_reg;       // live select pin stage 1
   logic        pin_s2_reg;       // live select pin stage 2
   logic        mot_s1_reg;       // motor supply stage 1
   logic        mot_s2_reg;       // motor supply stage 2
   logic [15:0] mv_s1_reg;        // voltage stage 1
   logic [15:0] mv_s2_reg;        // voltage stage 2
   boot_state_e state_reg;        // boot sequencer
   boot_state_e state_next;
   logic [8:0]  sw_id_reg;        // software axis id
   logic [8:0]  sw_id_next;
   logic [15:0] nv_word_reg;      // first nonvolatile word
   logic [15:0] nv_word_next;
   logic        prog_valid_reg;   // stored program valid
   logic        prog_valid_next;
   logic        ov_reg;           // over-voltage trip latched
   logic        ov_next;
   logic [EV_NUM-1:0] ist_reg;    // sticky events
   logic [EV_NUM-1:0] ist_next;
   logic [EV_NUM-1:0] imask_reg;  // event mask
   logic [EV_NUM-1:0] imask_next;
   logic [31:0] rdata_next;       // read data next
   logic [EV_NUM-1:0] events;     // event pulses this cycle
   logic        wr_en;            // apb write accepted
   logic        rd_en;            // apb read accepted
   logic        hit;              // mapped address
   logic        autorun_ok;       // autorun allowed this boot
   logic        over_limit;       // supply above trip level

   // strap capture
   strap_sampler u_sampler (
      .mclk           (mclk),
      .rst            (rst),
      .proto_sel_pin  (proto_sel_pin),
      .axis_id_switch (axis_id_switch),
      .straps         (straps)
   );

   // identifier mapping
   axis_id_resolve u_resolve (
      .straps               (straps),
      .has_switch           (HAS_SWITCH),
      .sw_id_setting        (sw_id_reg),
      .node_axis_identifier (id_comb)
   );

   // apb decode, zero wait states
   assign pready = 1'b1;
   assign wr_en  = psel & penable & pwrite;
   // read data loads in setup so it stands through the access phase
   assign rd_en  = psel & ~penable & ~pwrite;
   always_comb begin
      unique case (paddr)
         OFS_STATUS, OFS_SW_ID, OFS_NV_WORD,
         OFS_IRQ_STAT, OFS_IRQ_MASK, OFS_PROG_VAL: hit = 1'b1;
         default:                                   hit = 1'b0;
      endcase
   end
   assign pslverr = psel & penable & ~hit; // unmapped address errors

   // supply threshold
   assign over_limit = mv_s2_reg > OV_LIMIT_MV; // see [RULE16]

   // autorun only under vendor protocol, uncancelled, pin not grounded
   assign autorun_ok = ~straps.canopen // see [RULE3] [RULE7]
                     & (nv_word_reg != AUTORUN_CANCEL) // see [RULE5]
                     & pin_s2_reg; // see [RULE6]

   // boot sequencer next state
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         BOOT_SAMPLE: begin
            if (straps.latched) begin
               if (autorun_ok) // see [RULE3]
                  state_next = BOOT_WAIT;
               else // canopen, cancelled or pin grounded
                  state_next = BOOT_SLAVE;
            end
         end
         BOOT_WAIT: begin
            // program validity is judged when the motor supply comes up
            if (!autorun_ok) // see [RULE6] [RULE8]
               state_next = BOOT_SLAVE;
            else if (mot_s2_reg && !ov_reg) begin
               if (prog_valid_reg) // see [RULE4]
                  state_next = BOOT_RUN;
               else // see [RULE9]
                  state_next = BOOT_SLAVE;
            end
         end
         BOOT_RUN: begin
            if (straps.canopen) // see [RULE7]
               state_next = BOOT_SLAVE;
         end
         BOOT_SLAVE: begin
            state_next = BOOT_SLAVE; // stays until reset
         end
      endcase
   end

   // register writes and events
   always_comb begin
      sw_id_next      = sw_id_reg;
      nv_word_next    = nv_word_reg;
      prog_valid_next = prog_valid_reg;
      imask_next      = imask_reg;
      ov_next         = ov_reg | over_limit; // see [RULE16]
      events          = '0;
      events[EV_PROG_START] = (state_reg == BOOT_WAIT) &&
                              (state_next == BOOT_RUN);
      events[EV_OV_TRIP]    = over_limit & ~ov_reg;
      ist_next = ist_reg;
      if (wr_en) begin
         unique case (paddr)
            OFS_SW_ID:    sw_id_next = pwdata[8:0];
            OFS_NV_WORD:  nv_word_next = pwdata[15:0]; // see [RULE5]
            OFS_IRQ_STAT: ist_next = ist_reg & ~pwdata[EV_NUM-1:0];
            OFS_IRQ_MASK: imask_next = pwdata[EV_NUM-1:0];
            OFS_PROG_VAL: prog_valid_next = pwdata[0]; // see [RULE8]
            default:      ; // status and protocol are read only
         endcase // see [RULE2]
      end
      ist_next = ist_next | events; // set wins over clear
   end

   // read mux
   always_comb begin
      rdata_next = prdata;
      if (rd_en) begin
         unique case (paddr)
            OFS_STATUS: begin
               rdata_next = 32'h0000_0000;
               rdata_next[ST_CANOPEN] = straps.canopen;
               rdata_next[ST_AUTORUN] = (state_reg == BOOT_WAIT) ||
                                        (state_reg == BOOT_RUN);
               rdata_next[ST_RUNNING] = state_reg == BOOT_RUN;
               rdata_next[ST_OV_TRIP] = ov_reg;
               rdata_next[ST_ID_LSB +: 8] = id_reg;
            end
            OFS_SW_ID:    rdata_next = {23'h0, sw_id_reg};
            OFS_NV_WORD:  rdata_next = {16'h0, nv_word_reg};
            OFS_IRQ_STAT: rdata_next = {30'h0, ist_reg};
            OFS_IRQ_MASK: rdata_next = {30'h0, imask_reg};
            OFS_PROG_VAL: rdata_next = {31'h0, prog_valid_reg};
            default:      rdata_next = 32'h0000_0000;
         endcase
      end
   end

   // state registers
   always_ff @(posedge mclk) begin
      pin_s1_reg <= proto_sel_pin;
      pin_s2_reg <= pin_s1_reg;
      mot_s1_reg <= motor_supply_on;
      mot_s2_reg <= mot_s1_reg;
      mv_s1_reg  <= motor_supply_mv;
      mv_s2_reg  <= mv_s1_reg;
      if (rst) begin
         state_reg      <= BOOT_SAMPLE;
         sw_id_reg      <= SW_ID_HW_SELECT;
         nv_word_reg    <= 16'h0000;
         prog_valid_reg <= 1'b0;
         ov_reg         <= 1'b0;
         ist_reg        <= '0;
         imask_reg      <= '0;
         prdata         <= 32'h0000_0000;
         id_reg         <= 8'h00;
      end else begin
         state_reg      <= state_next;
         sw_id_reg      <= sw_id_next;
         nv_word_reg    <= nv_word_next;
         prog_valid_reg <= prog_valid_next;
         ov_reg         <= ov_next;
         ist_reg        <= ist_next;
         imask_reg      <= imask_next;
         prdata         <= rdata_next;
         id_reg         <= id_comb;
      end
   end

   // outputs
   assign canopen_selected     = straps.canopen; // see [RULE1]
   assign node_axis_identifier = id_reg;
   assign program_run          = state_reg == BOOT_RUN;
   assign power_stage_en       = ~ov_reg; // see [RULE16]
   assign irq                  = |(ist_reg & imask_reg);
endmodule
`default_nettype wire

// >>> shared/boot_cfg_pkg.sv
`default_nettype none
package boot_cfg_pkg;
   // apb register byte offsets
   localparam logic [7:0] OFS_STATUS    = 8'h00; // boot state, read only
   localparam logic [7:0] OFS_SW_ID     = 8'h04; // software axis id
   localparam logic [7:0] OFS_NV_WORD   = 8'h08; // first nonvolatile word
   localparam logic [7:0] OFS_IRQ_STAT  = 8'h0C; // sticky events, w1c
   localparam logic [7:0] OFS_IRQ_MASK  = 8'h10; // event enables
   localparam logic [7:0] OFS_PROG_VAL  = 8'h14; // program valid, bit 0 read/write
   // nonvolatile word address and the autorun cancel value
   localparam logic [15:0] NV_WORD_ADDR    = 16'h4000;
   localparam logic [15:0] AUTORUN_CANCEL  = 16'h0001;
   // axis identifier constants
   localparam logic [7:0] ID_VENDOR_ZERO  = 8'hFF; // switch 0, vendor
   localparam logic [7:0] ID_CANOPEN_ZERO = 8'h7F; // switch 0, canopen
   localparam logic [8:0] SW_ID_HW_SELECT = 9'h100; // hardware select
   // over-voltage limit in millivolts
   localparam logic [15:0] OV_LIMIT_MV = 16'hCF08; // 53000 mv
   // status field positions
   localparam int ST_CANOPEN = 0;
   localparam int ST_AUTORUN = 1;
   localparam int ST_RUNNING = 2;
   localparam int ST_OV_TRIP = 3;
   localparam int ST_ID_LSB  = 8;
   // event bit positions
   localparam int EV_PROG_START = 0;
   localparam int EV_OV_TRIP    = 1;
   localparam int EV_NUM        = 2;
   // boot sequencer states
   typedef enum logic [1:0] {
      BOOT_SAMPLE = 2'b00,
      BOOT_SLAVE  = 2'b01,
      BOOT_WAIT   = 2'b10,
      BOOT_RUN    = 2'b11
   } boot_state_e;
endpackage
`default_nettype wire

// >>> shared/boot_if.sv
`default_nettype none
// latched straps passed from sampler to identifier logic
interface boot_if;
   logic       canopen;     // protocol latched as canopen
   logic [3:0] switch_val;  // latched axis id switch
   logic       latched;     // straps captured
   modport src (output canopen, output switch_val, output latched);
   modport dst (input canopen, input switch_val, input latched);
endinterface
`default_nettype wire

// >>> design/strap_sampler.sv
`default_nettype none
// synchronises the straps and captures them once after reset release
module strap_sampler
   import boot_cfg_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic       proto_sel_pin,
   input  wire logic [3:0] axis_id_switch,
   boot_if.src             straps
);
   logic [4:0] sync1_reg;   // first synchroniser stage
   logic [4:0] sync2_reg;   // second synchroniser stage
   logic [4:0] held_reg;    // captured straps
   logic [4:0] held_next;
   logic       done_reg;    // capture done
   logic       done_next;

   // capture once, hold until next reset
   always_comb begin
      held_next = held_reg;
      done_next = done_reg;
      if (!done_reg) begin // see [RULE17]
         held_next = sync2_reg;
         done_next = 1'b1;
      end
   end

   // registers
   always_ff @(posedge mclk) begin
      sync1_reg <= {proto_sel_pin, axis_id_switch};
      sync2_reg <= sync1_reg;
      if (rst) begin
         held_reg <= 5'h10;
         done_reg <= 1'b0;
      end else begin
         held_reg <= held_next;
         done_reg <= done_next;
      end
   end

   // pin grounded means canopen, floating or high means vendor
   assign straps.canopen    = ~held_reg[4]; // see [RULE1]
   assign straps.switch_val = held_reg[3:0]; // see [RULE10]
   assign straps.latched   = done_reg;
endmodule
`default_nettype wire

// >>> design/axis_id_resolve.sv
`default_nettype none
// maps switch and software setting to the node axis identifier
module axis_id_resolve
   import boot_cfg_pkg::*;
(
   boot_if.dst             straps,
   input  wire logic       has_switch,
   input  wire logic [8:0] sw_id_setting,
   output logic      [7:0] node_axis_identifier
);
   logic [3:0] eff_switch; // switch value seen, zero if absent

   // switch position to identifier
   function automatic logic [7:0] map_id(input logic [3:0] sw,
                                         input logic canopen);
      if (sw == 4'h0)
         map_id = canopen ? ID_CANOPEN_ZERO : ID_VENDOR_ZERO;
      else
         map_id = {4'h0, sw};
   endfunction

   // resolve identifier
   always_comb begin
      eff_switch = has_switch ? straps.switch_val : 4'h0; // see [RULE14]
      if (sw_id_setting == SW_ID_HW_SELECT) // see [RULE13]
         node_axis_identifier = map_id(eff_switch, straps.canopen);
      else // see [RULE12]
         node_axis_identifier = sw_id_setting[7:0];
   end // see [RULE11]
endmodule
`default_nettype wire

// >>> dv/boot_cfg_checker.sv
`default_nettype none
// watches the boot block ports for bus, strap and trip behaviour
module boot_cfg_checker
   import boot_cfg_pkg::*;
(
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic        pslverr,
   input wire logic [31:0] prdata,
   input wire logic        canopen_selected,
   input wire logic        program_run,
   input wire logic        power_stage_en,
   input wire logic [15:0] motor_supply_mv
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   // access phase and unmapped decode
   wire logic acc = psel && penable;
   wire logic bad = (paddr > OFS_PROG_VAL) || (paddr[1:0] != 2'b00);
   wire logic over = motor_supply_mv > OV_LIMIT_MV;
   bad_addr_a: assert property (acc && bad |-> pslverr)
      else $error("no error on unmapped access");
   good_addr_a: assert property (acc && !bad |-> !pslverr)
      else $error("error on mapped access");
   read_zero_a: assert property (acc && !pwrite && bad |=> prdata == 32'h0)
      else $error("unmapped read not zero");
   rdata_hold_a: assert property (!(psel && !penable && !pwrite)
      |=> $stable(prdata))
      else $error("read data moved without a read");
   strap_hold_a: assert property (!$past(rst) && !$past(rst, 2) |->
      $stable(canopen_selected)) else $error("protocol changed after boot");
   canopen_norun_a: assert property (canopen_selected |-> !program_run)
      else $error("program runs under canopen");
   ov_trip_a: assert property (over [*4] |-> ##[0:4] !power_stage_en)
      else $error("no trip above limit");
   ov_cause_a: assert property ($fell(power_stage_en) |-> $past(over, 3))
      else $error("trip without over-voltage");
   ov_latch_a: assert property (!power_stage_en |=> !power_stage_en)
      else $error("trip released before reset");
   // main scenarios reached
   cover property ($rose(program_run));
   cover property ($fell(power_stage_en));
   cover property (acc && pslverr);
endmodule
bind drive_boot_config_select boot_cfg_checker chk_u (.*);
`default_nettype wire

// >>> dv/strap_board_model.sv
`default_nettype none
// select strap net shared by two connector pins, pulled up when floating
module strap_board_model (
   input  wire logic gnd_a,        // first connector pin grounded
   input  wire logic gnd_b,        // second connector pin grounded
   output logic      proto_sel_pin // net level seen by the drive
);
   timeunit 1ns;
   timeprecision 1ps;
   // pull-up wins unless a pin is grounded
   assign proto_sel_pin = !(gnd_a || gnd_b);
endmodule
`default_nettype wire

// >>> dv/test_drive_boot_config_select.sv
`default_nettype none
module test_drive_boot_config_select
   import boot_cfg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk, rst = 1'b1, gnd_sel = 1'b0, motor_supply_on = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        pready, pslverr, canopen_selected, program_run;
   logic        power_stage_en, irq;
   wire logic   proto_sel_pin;
   logic [3:0]  axis_id_switch = 4'h0;
   logic [15:0] motor_supply_mv = 16'hBB80;
   logic [7:0]  paddr = 8'h00;
   logic [7:0]  node_axis_identifier, id_nosw;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   int          err_total, compares;
   // both select pins always wired to one level
   strap_board_model board_u (.gnd_a(gnd_sel), .gnd_b(gnd_sel),
      .proto_sel_pin(proto_sel_pin));
   drive_boot_config_select #(.HAS_SWITCH(1'b1)) dut_u (.*);
   // variant without a switch, sharing bus and straps
   drive_boot_config_select #(.HAS_SWITCH(1'b0)) nosw_u (.*, .pready(),
      .pslverr(), .prdata(), .canopen_selected(), .program_run(),
      .node_axis_identifier(id_nosw), .power_stage_en(), .irq());
   // 250 mhz clock
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   // compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // verdict and end of run
   task automatic close_out();
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // one apb transfer, read data taken at the access edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk) penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         err_total++;
         close_out();
      end
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask
   // reset with given straps, supply off and nominal
   task automatic boot(input logic gnd, input logic [3:0] sw);
      rst <= 1'b1;
      gnd_sel <= gnd;
      axis_id_switch <= sw;
      motor_supply_on <= 1'b0;
      motor_supply_mv <= 16'hBB80;
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      repeat (6) @(posedge mclk);
   endtask
   // bounded wait for a program start, then compare
   task automatic run_chk(input logic exp);
      int n;
      n = 0;
      while (program_run !== 1'b1 && n < 20) begin
         @(posedge mclk);
         n++;
      end
      chk(32'(program_run), 32'(exp));
   endtask
   // stored program, optional pin pulse and cancel, then supply on
   task automatic autorun(input logic gnd, input logic pulse,
                          input logic cancel, input logic exp);
      boot(gnd, 4'h3);
      apb(1'b1, OFS_PROG_VAL, 32'h1, rd);
      if (pulse) begin
         gnd_sel <= 1'b1;
         repeat (4) @(posedge mclk);
         gnd_sel <= 1'b0;
      end
      if (cancel)
         apb(1'b1, OFS_NV_WORD, 32'(AUTORUN_CANCEL), rd);
      motor_supply_on <= 1'b1;
      run_chk(exp);
   endtask
   // hang guard
   initial begin
      repeat (100000) @(posedge mclk);
      err_total++;
      close_out();
   end
   // main sequence
   initial begin
      logic [7:0] ex;
      for (int g = 0; g < 2; g++) begin
         for (int s = 0; s < 16; s++) begin
            boot(g[0], s[3:0]);
            ex = (s == 0) ? (g[0] ? ID_CANOPEN_ZERO : ID_VENDOR_ZERO) : 8'(s);
            chk(32'(node_axis_identifier), 32'(ex));
            chk(32'(canopen_selected), 32'(g));
            chk(32'(id_nosw), 32'(g[0] ? ID_CANOPEN_ZERO : ID_VENDOR_ZERO));
            apb(1'b0, OFS_STATUS, 32'h0, rd);
            chk(32'({rd[15:8], rd[ST_CANOPEN]}), 32'({ex, g[0]}));
            axis_id_switch <= ~s[3:0];
            gnd_sel <= ~g[0];
            motor_supply_on <= 1'b1;
            run_chk(1'b0);
            chk(32'(node_axis_identifier), 32'(ex));
            chk(32'(canopen_selected), 32'(g));
         end
      end
      // protocol is pin only, software id override
      boot(1'b0, 4'h3);
      apb(1'b1, OFS_STATUS, 32'h1, rd);
      apb(1'b0, OFS_STATUS, 32'h0, rd);
      chk(32'({rd[ST_CANOPEN], canopen_selected}), 32'h0);
      apb(1'b0, OFS_SW_ID, 32'h0, rd);
      chk(rd, 32'(SW_ID_HW_SELECT));
      apb(1'b1, OFS_SW_ID, 32'h5A, rd);
      apb(1'b0, 8'h18, 32'h0, rd);
      chk(rd, 32'h0);
      chk(32'(node_axis_identifier), 32'h5A);
      apb(1'b1, OFS_SW_ID, 32'(SW_ID_HW_SELECT), rd);
      apb(1'b0, OFS_SW_ID, 32'h0, rd);
      chk(32'(node_axis_identifier), 32'h3);
      // autorun cases
      autorun(1'b0, 1'b0, 1'b0, 1'b1);
      apb(1'b0, OFS_IRQ_STAT, 32'h0, rd);
      chk(32'({rd[EV_PROG_START], irq}), 32'h2);
      apb(1'b1, OFS_IRQ_MASK, 32'h1, rd);
      apb(1'b0, OFS_IRQ_MASK, 32'h0, rd);
      chk(32'(irq), 32'h1);
      apb(1'b1, OFS_IRQ_STAT, 32'h1, rd);
      apb(1'b0, OFS_IRQ_STAT, 32'h0, rd);
      chk(32'({rd[EV_PROG_START], irq}), 32'h0);
      autorun(1'b0, 1'b0, 1'b1, 1'b0);
      autorun(1'b0, 1'b1, 1'b0, 1'b0);
      autorun(1'b0, 1'b1, 1'b1, 1'b0);
      autorun(1'b1, 1'b0, 1'b0, 1'b0);
      // over-voltage: at the limit no trip, one above trips and latches
      boot(1'b0, 4'h1);
      motor_supply_mv <= OV_LIMIT_MV;
      repeat (8) @(posedge mclk);
      chk(32'(power_stage_en), 32'h1);
      motor_supply_mv <= OV_LIMIT_MV + 16'h0001;
      for (int n = 0; n < 20 && power_stage_en === 1'b1; n++)
         @(posedge mclk);
      chk(32'(power_stage_en), 32'h0);
      motor_supply_mv <= 16'hBB80;
      apb(1'b0, OFS_IRQ_STAT, 32'h0, rd);
      chk(32'(rd[EV_OV_TRIP]), 32'h1);
      chk(32'(power_stage_en), 32'h0);
      close_out();
   end
endmodule
`default_nettype wire
